/* File: design/irq_bank_pkg.sv */
// Constants, field layout and types shared by the peripheral interrupt enable banks
package irq_bank_pkg;
  // ---------------------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------------------
  localparam int unsigned addr_w = 8;
  localparam int unsigned data_w = 32;
  localparam int unsigned bank_w = 8;
  localparam logic [7:0] off_enable_bank2 = 8'h00;
  localparam logic [7:0] off_enable_bank3 = 8'h04;
  localparam logic [7:0] off_irq_control = 8'h08;
  localparam logic [7:0] off_flag_bank2 = 8'h0C;
  localparam logic [7:0] off_flag_bank3 = 8'h10;
  localparam logic [7:0] off_pending = 8'h14;
  localparam logic [1:0] align_mask = 2'h3;
  localparam int unsigned strb_lane0 = 0;
  localparam logic [7:0] bank_reset = 8'h00;
  localparam logic ctrl_reset = 1'b0;
  localparam int unsigned ctrl_global_peripheral_irq_enable_bit = 0;
  localparam int unsigned pending_bank3_lsb = 8;
  // ---------------------------------------------------------------------------
  // Bit positions, first bank
  // ---------------------------------------------------------------------------
  localparam int unsigned osc_fail_bit = 7;
  localparam int unsigned clock_switch_bit = 6;
  localparam int unsigned timer_c_gate_bit = 5;
  localparam int unsigned timer_c_overflow_bit = 4;
  localparam int unsigned logic_cell_d_bit = 3;
  localparam int unsigned logic_cell_c_bit = 2;
  localparam int unsigned logic_cell_b_bit = 1;
  localparam int unsigned logic_cell_a_bit = 0;
  // ---------------------------------------------------------------------------
  // Bit positions, second bank
  // ---------------------------------------------------------------------------
  localparam int unsigned waveform_gen_b_bit = 7;
  localparam int unsigned waveform_gen_a_bit = 6;
  localparam int unsigned timer_e_gate_bit = 5;
  localparam int unsigned timer_e_overflow_bit = 4;
  localparam int unsigned capcmp_d_bit = 3;
  localparam int unsigned capcmp_c_bit = 2;
  localparam int unsigned capcmp_b_bit = 1;
  localparam int unsigned capcmp_a_bit = 0;
  // ---------------------------------------------------------------------------
  // Bus handshake states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_access = 2'b10
  } apb_state_e;
endpackage : irq_bank_pkg

/* File: design/irq_bank_if.sv */
// Interfaces that carry signals between the top and its three submodules
`timescale 1ns/1ps
`default_nettype none
interface bank_if;
  logic wr_enable;
  logic wr_clear;
  logic [7:0] wdata;
  logic [7:0] event_in;
  logic [7:0] enable;
  logic [7:0] flag;
  logic [7:0] pending;
  modport bank (input wr_enable, input wr_clear, input wdata, input event_in,
                output enable, output flag, output pending);
  modport ctrl (output wr_enable, output wr_clear, output wdata, output event_in,
                input enable, input flag, input pending);
endinterface : bank_if

interface apb_port_if;
  logic psel;
  logic penable;
  logic pwrite;
  logic ready;
  logic wr_take;
  logic rd_capture;
  modport fsm (input psel, input penable, input pwrite,
               output ready, output wr_take, output rd_capture);
  modport ctrl (output psel, output penable, output pwrite,
                input ready, input wr_take, input rd_capture);
endinterface : apb_port_if
`default_nettype wire

/* File: design/irq_source_bank.sv */
// One bank of eight enable bits and eight sticky source flags
`timescale 1ns/1ps
`default_nettype none
module irq_source_bank
  import irq_bank_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  bank_if.bank b
);
  logic [7:0] enable;
  logic [7:0] flag;
  logic [7:0] next_enable;
  logic [7:0] next_flag;

  always_comb begin
    next_enable = b.wr_enable ? b.wdata : enable;
  end

  // ---------------------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------------------
  // Event beats a write-one-to-clear in the same cycle, so no event is lost
  for (genvar i = 0; i < bank_w; i++) begin : g_flag
    assign next_flag[i] = b.event_in[i] | (flag[i] & ~(b.wr_clear & b.wdata[i]));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= bank_reset;
      flag <= bank_reset;
    end else begin
      enable <= next_enable;
      flag <= next_flag;
    end
  end

  assign b.enable = enable;
  assign b.flag = flag;
  assign b.pending = flag & enable;
endmodule : irq_source_bank
`default_nettype wire

/* File: design/apb_access_fsm.sv */
// APB setup/access sequencing with zero wait states
`timescale 1ns/1ps
`default_nettype none
module apb_access_fsm
  import irq_bank_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  apb_port_if.fsm p
);
  apb_state_e state;
  apb_state_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (p.psel && !p.penable) begin
          next_state = st_access;
        end
      end
      st_access: begin
        next_state = st_idle;
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Read data are sampled at the setup edge so prdata is a flop in the access cycle
  assign p.ready = (state == st_access);
  assign p.wr_take = (state == st_access) && p.psel && p.penable && p.pwrite;
  assign p.rd_capture = (state == st_idle) && p.psel && !p.penable && !p.pwrite;
endmodule : apb_access_fsm
`default_nettype wire

/* File: design/periph_irq_enable_top.sv */
// Peripheral interrupt enable banks two and three with flags, global gate and APB access
//
// Operation
// - No bank interrupt reaches the core unless the global peripheral enable is set.
// - First bank bit 6 enables the clock switch completion interrupt.
// - First bank bit 5 enables the third timer gate interrupt.
// - First bank bits 3 to 0 enable logic cells four to one.
// - Second bank bits 7 and 6 enable waveform generators two and one.
// - Second bank bit 5 enables the fifth timer gate interrupt.
// - Second bank bit 4 enables the fifth timer overflow interrupt.
// - Second bank bits 3 to 0 enable capture/compare units four to one.
// - Source flags set on their event regardless of any enable bit.
`timescale 1ns/1ps
`default_nettype none
module periph_irq_enable_top
  import irq_bank_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] bank2_event,
  input wire logic [7:0] bank3_event,
  output logic irq,
  output logic osc_fail_irq_en,
  output logic clock_switch_done_irq_en,
  output logic timer_c_gate_irq_en,
  output logic timer_c_overflow_irq_en,
  output logic logic_cell_d_irq_en,
  output logic logic_cell_c_irq_en,
  output logic logic_cell_b_irq_en,
  output logic logic_cell_a_irq_en,
  output logic waveform_gen_b_irq_en,
  output logic waveform_gen_a_irq_en,
  output logic timer_e_gate_irq_en,
  output logic timer_e_overflow_irq_en,
  output logic capcmp_d_irq_en,
  output logic capcmp_c_irq_en,
  output logic capcmp_b_irq_en,
  output logic capcmp_a_irq_en
);
  // ---------------------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------------------
  bank_if b2 ();
  bank_if b3 ();
  apb_port_if ap ();

  apb_access_fsm u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .p(ap.fsm)
  );

  irq_source_bank u_bank2 (
    .pclk(pclk),
    .presetn(presetn),
    .b(b2.bank)
  );

  irq_source_bank u_bank3 (
    .pclk(pclk),
    .presetn(presetn),
    .b(b3.bank)
  );

  assign ap.psel = psel;
  assign ap.penable = penable;
  assign ap.pwrite = pwrite;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  logic aligned;
  logic hit_enable2;
  logic hit_enable3;
  logic hit_control;
  logic hit_flag2;
  logic hit_flag3;
  logic hit_pending;
  logic addr_hit;
  logic lane0;
  logic wr_ok;

  assign aligned = ((paddr[1:0] & align_mask) == 2'h0);
  always_comb begin
    hit_enable2 = 1'b0;
    hit_enable3 = 1'b0;
    hit_control = 1'b0;
    hit_flag2 = 1'b0;
    hit_flag3 = 1'b0;
    hit_pending = 1'b0;
    case (paddr)
      off_enable_bank2: begin
        hit_enable2 = 1'b1;
      end
      off_enable_bank3: begin
        hit_enable3 = 1'b1;
      end
      off_irq_control: begin
        hit_control = 1'b1;
      end
      off_flag_bank2: begin
        hit_flag2 = 1'b1;
      end
      off_flag_bank3: begin
        hit_flag3 = 1'b1;
      end
      off_pending: begin
        hit_pending = 1'b1;
      end
      default: begin
        hit_pending = 1'b0;
      end
    endcase
  end
  assign addr_hit = aligned & (hit_enable2 | hit_enable3 | hit_control | hit_flag2 | hit_flag3 | hit_pending);

  // Only the low byte lane carries state; a write with that lane off stores nothing
  assign lane0 = pstrb[strb_lane0];
  assign wr_ok = ap.wr_take & lane0;

  // ---------------------------------------------------------------------------
  // Bank write strobes
  // ---------------------------------------------------------------------------
  // The pending word gets no strobe, so a write to it falls away without an error
  logic wr_enable2;
  logic wr_enable3;
  logic wr_clear2;
  logic wr_clear3;

  always_comb begin
    wr_enable2 = 1'b0;
    wr_enable3 = 1'b0;
    wr_clear2 = 1'b0;
    wr_clear3 = 1'b0;
    if (wr_ok) begin
      wr_enable2 = hit_enable2;
      wr_enable3 = hit_enable3;
      wr_clear2 = hit_flag2;
      wr_clear3 = hit_flag3;
    end
  end

  assign b2.wr_enable = wr_enable2;
  assign b3.wr_enable = wr_enable3;
  assign b2.wr_clear = wr_clear2;
  assign b3.wr_clear = wr_clear3;
  assign b2.wdata = pwdata[7:0];
  assign b3.wdata = pwdata[7:0];
  assign b2.event_in = bank2_event;
  assign b3.event_in = bank3_event;

  // ---------------------------------------------------------------------------
  // Interrupt control register
  // ---------------------------------------------------------------------------
  logic global_peripheral_irq_enable;
  logic next_global_peripheral_irq_enable;

  always_comb begin
    next_global_peripheral_irq_enable = global_peripheral_irq_enable;
    if (wr_ok && hit_control) begin
      next_global_peripheral_irq_enable = pwdata[ctrl_global_peripheral_irq_enable_bit];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_peripheral_irq_enable <= ctrl_reset;
    end else begin
      global_peripheral_irq_enable <= next_global_peripheral_irq_enable;
    end
  end

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  logic [31:0] read_value;
  logic [31:0] interrupt_control_reg;
  logic [15:0] pending_all;

  assign pending_all = {b3.pending, b2.pending};

  always_comb begin
    interrupt_control_reg = 32'h0000_0000;
    interrupt_control_reg[ctrl_global_peripheral_irq_enable_bit] = global_peripheral_irq_enable;
  end

  always_comb begin
    read_value = 32'h0000_0000;
    if (aligned) begin
      case (paddr)
        off_enable_bank2: begin
          read_value = {24'h00_0000, b2.enable};
        end
        off_enable_bank3: begin
          read_value = {24'h00_0000, b3.enable};
        end
        off_irq_control: begin
          read_value = interrupt_control_reg;
        end
        off_flag_bank2: begin
          read_value = {24'h00_0000, b2.flag};
        end
        off_flag_bank3: begin
          read_value = {24'h00_0000, b3.flag};
        end
        off_pending: begin
          read_value = {16'h0000, pending_all};
        end
        default: begin
          read_value = 32'h0000_0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Read data register
  // ---------------------------------------------------------------------------
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = prdata;
    if (ap.rd_capture) begin
      next_prdata = read_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------------------
  // Unmapped or misaligned addresses answer with an error and change nothing
  assign pready = ap.ready;
  assign pslverr = ap.ready & ~addr_hit;

  // ---------------------------------------------------------------------------
  // Request to the core
  // ---------------------------------------------------------------------------
  // Registered so the core sees a clean level; costs one cycle of latency
  logic [15:0] gated_request;
  logic next_irq;

  // One gate per source; the global enable stands in front of every bank bit
  for (genvar s = 0; s < 2 * bank_w; s++) begin : g_gate
    assign gated_request[s] = pending_all[s] & global_peripheral_irq_enable;
  end

  always_comb begin
    next_irq = |gated_request;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ---------------------------------------------------------------------------
  // Enable fan-out, first bank
  // ---------------------------------------------------------------------------
  assign osc_fail_irq_en = b2.enable[osc_fail_bit];
  assign clock_switch_done_irq_en = b2.enable[clock_switch_bit];
  assign timer_c_gate_irq_en = b2.enable[timer_c_gate_bit];
  assign timer_c_overflow_irq_en = b2.enable[timer_c_overflow_bit];
  assign logic_cell_d_irq_en = b2.enable[logic_cell_d_bit];
  assign logic_cell_c_irq_en = b2.enable[logic_cell_c_bit];
  assign logic_cell_b_irq_en = b2.enable[logic_cell_b_bit];
  assign logic_cell_a_irq_en = b2.enable[logic_cell_a_bit];

  // ---------------------------------------------------------------------------
  // Enable fan-out, second bank
  // ---------------------------------------------------------------------------
  assign waveform_gen_b_irq_en = b3.enable[waveform_gen_b_bit];
  assign waveform_gen_a_irq_en = b3.enable[waveform_gen_a_bit];
  assign timer_e_gate_irq_en = b3.enable[timer_e_gate_bit];
  assign timer_e_overflow_irq_en = b3.enable[timer_e_overflow_bit];
  assign capcmp_d_irq_en = b3.enable[capcmp_d_bit];
  assign capcmp_c_irq_en = b3.enable[capcmp_c_bit];
  assign capcmp_b_irq_en = b3.enable[capcmp_b_bit];
  assign capcmp_a_irq_en = b3.enable[capcmp_a_bit];
endmodule : periph_irq_enable_top
`default_nettype wire

/* File: sim/irq_bank_checker.sv */
// Port assertions for the peripheral interrupt enable banks
`timescale 1ns/1ps
`default_nettype none
module irq_bank_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic [7:0] en2,
  input wire logic [7:0] en3
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wdone;
  logic [7:0] wbyte;
  logic anyen;
  assign wdone = psel && penable && pwrite && pready && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign anyen = |{en2, en3};
  a_bank2_write: assert property (wdone && paddr == 8'h00 |=> en2 == $past(wbyte))
    else $error("first bank pins differ from written byte");
  a_bank3_write: assert property (wdone && paddr == 8'h04 |=> en3 == $past(wbyte))
    else $error("second bank pins differ from written byte");
  a_enable_hold: assert property (!(psel && penable && pwrite) |=> $stable(en2) && $stable(en3))
    else $error("enable pins moved without a write");
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held over two cycles");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_error: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
  a_irq_needs_enable: assert property (irq |-> $past(anyen))
    else $error("interrupt with no enable set");
endmodule : irq_bank_checker

bind periph_irq_enable_top irq_bank_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .irq(irq),
  .en2({osc_fail_irq_en, clock_switch_done_irq_en, timer_c_gate_irq_en, timer_c_overflow_irq_en,
    logic_cell_d_irq_en, logic_cell_c_irq_en, logic_cell_b_irq_en, logic_cell_a_irq_en}),
  .en3({waveform_gen_b_irq_en, waveform_gen_a_irq_en, timer_e_gate_irq_en, timer_e_overflow_irq_en,
    capcmp_d_irq_en, capcmp_c_irq_en, capcmp_b_irq_en, capcmp_a_irq_en}));
`default_nettype wire

/* File: sim/event_source_model.sv */
// Peripheral sources that pulse the bank event inputs
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
  input wire logic pclk,
  output logic [7:0] bank2_event,
  output logic [7:0] bank3_event
);
  initial begin
    bank2_event = 8'h00;
    bank3_event = 8'h00;
  end
  // One-cycle pulse; sources fire whatever the enables hold
  task automatic pulse(input logic b3, input logic [7:0] m);
    @(posedge pclk);
    if (b3) begin
      bank3_event <= m;
    end else begin
      bank2_event <= m;
    end
    @(posedge pclk);
    bank2_event <= 8'h00;
    bank3_event <= 8'h00;
  endtask : pulse
endmodule : event_source_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the peripheral interrupt enable banks
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import irq_bank_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [7:0] bank2_event;
  logic [7:0] bank3_event;
  logic [7:0] en2;
  logic [7:0] en3;
  logic [31:0] rdv;
  logic err;
  logic [7:0] d;
  logic [7:0] m;
  logic [7:0] ea;
  logic [7:0] fa;
  int miscompares;
  int n_tests;
  int seed;
  event_source_model src_u (.pclk(pclk), .bank2_event(bank2_event), .bank3_event(bank3_event));
  periph_irq_enable_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bank2_event(bank2_event), .bank3_event(bank3_event), .irq(irq),
    .osc_fail_irq_en(en2[7]), .clock_switch_done_irq_en(en2[6]), .timer_c_gate_irq_en(en2[5]),
    .timer_c_overflow_irq_en(en2[4]), .logic_cell_d_irq_en(en2[3]), .logic_cell_c_irq_en(en2[2]),
    .logic_cell_b_irq_en(en2[1]), .logic_cell_a_irq_en(en2[0]), .waveform_gen_b_irq_en(en3[7]),
    .waveform_gen_a_irq_en(en3[6]), .timer_e_gate_irq_en(en3[5]), .timer_e_overflow_irq_en(en3[4]),
    .capcmp_d_irq_en(en3[3]), .capcmp_c_irq_en(en3[2]), .capcmp_b_irq_en(en3[1]), .capcmp_a_irq_en(en3[0]));
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] bit_of(input int i);
    return 8'h01 << i;
  endfunction : bit_of
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Master waits for ready with no assumed latency; the bound is the only timeout
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (n == 20) begin
      miscompares++;
      report_and_stop();
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'h1, a, {24'h000000, v}, 4'hF);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h00000000, 4'h0);
  endtask : rd
  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    seed = 32'h7E49;
    miscompares = 0;
    n_tests = 0;
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd(off_enable_bank2);
    check("bank2 reset", 32'h00000000, rdv);
    rd(off_enable_bank3);
    check("bank3 reset", 32'h00000000, rdv);
    $display("test reset done");
    for (int k = 0; k < 10; k++) begin
      d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
      wr(off_enable_bank2, d);
      wr(off_enable_bank3, ~d);
      @(posedge pclk);
      check("bank2 pins", {24'h0, d}, {24'h0, en2});
      check("bank3 pins", {24'h0, ~d}, {24'h0, en3});
      rd(off_enable_bank2);
      check("bank2 read", {24'h0, d}, rdv);
      rd(off_enable_bank3);
      check("bank3 read", {24'h0, ~d}, rdv);
    end
    $display("test readback done");
    // Each source alone: masked by its neighbours, held off by the global gate, then raised
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 8; i++) begin
        ea = b ? off_enable_bank3 : off_enable_bank2;
        fa = b ? off_flag_bank3 : off_flag_bank2;
        m = bit_of(i);
        wr(off_enable_bank2, 8'h00);
        wr(off_enable_bank3, 8'h00);
        wr(fa, 8'hFF);
        wr(ea, m);
        wr(off_irq_control, 8'h01);
        rd(off_irq_control);
        check("control read", 32'h1, rdv);
        src_u.pulse(b[0], ~m);
        repeat (3) @(posedge pclk);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(off_irq_control, 8'h00);
        src_u.pulse(b[0], m);
        repeat (3) @(posedge pclk);
        check("irq global off", 32'h0, {31'h0, irq});
        rd(fa);
        check("flag set", 32'h000000FF, rdv);
        wr(off_irq_control, 8'h01);
        repeat (2) @(posedge pclk);
        check("irq raised", 32'h1, {31'h0, irq});
        rd(off_pending);
        check("pending", b ? {16'h0, m, 8'h00} : {24'h0, m}, rdv);
        wr(fa, m);
        repeat (2) @(posedge pclk);
        check("irq cleared", 32'h0, {31'h0, irq});
      end
    end
    $display("test interrupt done");
    wr(off_enable_bank2, 8'h5A);
    apb(1'h1, off_enable_bank2, 32'h000000A5, 4'h0);
    @(posedge pclk);
    check("strobe off", 32'h5A, {24'h0, en2});
    apb(1'h0, 8'h40, 32'h00000000, 4'h0);
    check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rdv);
    apb(1'h1, 8'h01, 32'h000000FF, 4'hF);
    check("misaligned err", 32'h1, {31'h0, err});
    @(posedge pclk);
    check("misaligned keep", 32'h5A, {24'h0, en2});
    $display("test refusal done");
    wr(off_enable_bank3, 8'hFF);
    presetn <= 1'h0;
    @(posedge pclk);
    @(posedge pclk);
    check("reset pins", 32'h0, {15'h0, irq, en2, en3});
    presetn <= 1'h1;
    rd(off_enable_bank3);
    check("bank3 after reset", 32'h0, rdv);
    $display("test midrun reset done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
